// *** bench/isp_link_sva.sv ***
// Checker for the link between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
module isp_link_sva
  import isp_interlock_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link signals watched
  input wire logic fl_req,
  input wire logic [1:0] fl_op,
  input wire logic fl_rvalid,
  input wire logic fl_busy,
  input wire logic realtime_prog_busy,
  input wire logic prog_complete_flag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Reads are answered in the next cycle
  a_read_answered: assert property (fl_req && fl_op == FL_OP_READ |=> fl_rvalid)
    else $error("flash read not answered");
  // An answer always has a read behind it
  a_answer_cause: assert property (fl_rvalid |-> $past(fl_req) && $past(fl_op) == FL_OP_READ)
    else $error("flash answer without read");
  // Writes and erases give no answer
  a_no_answer: assert property (fl_req && fl_op != FL_OP_READ |=> !fl_rvalid)
    else $error("answer after write or erase");
  // Nothing reaches the flash during a real-time session
  a_rt_quiet: assert property (realtime_prog_busy |-> !fl_req)
    else $error("flash request in real-time session");
  // Nothing reaches the flash while it is busy
  a_busy_quiet: assert property (fl_busy |-> !fl_req)
    else $error("flash request while busy");
  // Flag stays clear inside an open real-time session
  a_flag_open: assert property (realtime_prog_busy [*3] |-> !prog_complete_flag)
    else $error("complete flag set mid session");
  // A write holds busy for a bounded time
  a_write_time: assert property (fl_req && fl_op == FL_OP_WRITE |=> fl_busy [*8] ##[1:30] !fl_busy)
    else $error("write time wrong");
  // An erase ends inside the real-time wait
  a_erase_time: assert property (fl_req && fl_op == FL_OP_ERASE |=> fl_busy [*8] ##[1:50] !fl_busy)
    else $error("erase time wrong");
endmodule : isp_link_sva
`default_nettype wire

// *** bench/test_isp_flash_interlock.sv ***
// Testbench joining host end and device end over the link
`timescale 1ns/1ns
`default_nettype none
module test_isp_flash_interlock;
  import isp_interlock_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic core_power_ok = 1'b1;
  logic power_good = 1'b0;  // Board power, raised late in the first session
  logic [7:0] user_out = 8'hA5, user_oe = 8'hFF, clamp_val = 8'h3C, clamp_oe = 8'hFF;
  logic [7:0] pad_out, pad_oe, pad_pullup;
  logic tdi_pullup, tms_pullup, tck_pulldown;
  logic [31:0] s;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  isp_link_if link ();
  isp_host_end #(.WAIT_CYC(60)) i_isp_host_end (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .power_good(power_good), .link(link));
  isp_device_end #(.ERASE_CYC(50), .WRITE_CYC(20)) i_isp_device_end (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link), .core_power_ok(core_power_ok),
    .user_out(user_out), .user_oe(user_oe), .clamp_val(clamp_val), .clamp_oe(clamp_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .tdi_pullup(tdi_pullup),
    .tms_pullup(tms_pullup), .tck_pulldown(tck_pulldown));
  isp_link_sva i_isp_link_sva (.core_clk(core_clk), .sys_rst(sys_rst), .fl_req(link.fl_req),
    .fl_op(link.fl_op), .fl_rvalid(link.fl_rvalid), .fl_busy(link.fl_busy),
    .realtime_prog_busy(link.realtime_prog_busy), .prog_complete_flag(link.prog_complete_flag));
  // Clock, 10 ns period
  always #5 core_clk = ~core_clk;
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Verdict and end of run
  task automatic test_done;
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Poll one register bit under a bounded count
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] d;
    for (int i = 0; i < 3000; i++) begin
      rd(a, d);
      if (d[b] === v) return;
    end
    chk("poll", {31'h0, d[b]}, {31'h0, v});
  endtask : wait_bit
  // Flash command through the controller, waits for its flash event
  task automatic flop(input logic [1:0] op, input logic [3:0] a, input logic [15:0] d);
    wr(REG_IRQ_ST, 32'h2);
    wr(REG_FL_CMD, {d, 4'h0, a, 6'h0, op});
    wait_bit(REG_IRQ_ST, EV_FLASH, 1'b1);
  endtask : flop
  // Cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 chk("pad_oe", {24'h0, pad_oe}, 32'h0);
    chk("pulls", {29'h0, tdi_pullup, tms_pullup, tck_pulldown}, 32'h7);
    chk("tdo_oe", {31'h0, link.tdo_oe}, 32'h0);
    // Flash read, write, erase; interrupt masked in, then cleared
    wr(REG_IRQ_MASK, 32'h2);
    flop(FL_OP_READ, 4'h3, 16'h0);
    #1 chk("irq", {31'h0, irq}, 32'h1);
    rd(REG_FL_DATA, s);
    chk("fresh", s, 32'hFFFF);
    flop(FL_OP_WRITE, 4'h3, 16'h1234);
    flop(FL_OP_READ, 4'h3, 16'h0);
    rd(REG_FL_DATA, s);
    chk("written", s, 32'h1234);
    flop(FL_OP_ERASE, 4'h3, 16'h0);
    flop(FL_OP_READ, 4'h3, 16'h0);
    rd(REG_FL_DATA, s);
    chk("erased", s, 32'hFFFF);
    wr(REG_IRQ_ST, 32'h7);
    wr(REG_IRQ_MASK, 32'h4);
    #1 chk("irq clear", {31'h0, irq}, 32'h0);
    // Plain session started behind a pending write, board power late
    wr(REG_FL_CMD, {16'h00F0, 4'h0, 4'h5, 6'h0, FL_OP_WRITE});
    wr(REG_CTRL, 32'h1);
    repeat (100) @(posedge core_clk);
    rd(REG_STATUS, s);
    chk("parked", {28'h0, s[5], s[1], link.tck, link.tms}, 32'h9);
    @(posedge core_clk);
    power_good <= 1'b1;
    wait_bit(REG_STATUS, 1, 1'b1);
    repeat (120) @(posedge core_clk);
    #1 chk("pad_oe", {24'h0, pad_oe}, 32'h0);
    chk("pad_pullup", {24'h0, pad_pullup}, 32'hFF);
    wr(REG_FL_CMD, {16'h0, 4'h0, 4'h5, 6'h0, FL_OP_READ});
    rd(REG_IRQ_ST, s);
    chk("refused", s, 32'h6);
    #1 chk("irq refused", {31'h0, irq}, 32'h1);
    wait_bit(REG_STATUS, 5, 1'b0);
    rd(REG_STATUS, s);
    chk("flag", {31'h0, s[3]}, 32'h1);
    chk("pads", {pad_out, pad_oe, pad_pullup}, 32'hA5FF00);
    flop(FL_OP_READ, 4'h5, 16'h0);
    rd(REG_FL_DATA, s);
    chk("kept write", s, 32'h00F0);
    // Real-time and clamp sessions, each behind a fresh erase
    for (int k = 0; k < 2; k++) begin
      wr(REG_FL_CMD, {16'h0, 4'h0, 4'h5, 6'h0, FL_OP_ERASE});
      wr(REG_CTRL, (k == 0) ? 32'h3 : 32'h5);
      wait_bit(REG_STATUS, 1, 1'b1);
      repeat (120) @(posedge core_clk);
      #1 chk("rt busy", {31'h0, link.realtime_prog_busy}, (k == 0) ? 32'h1 : 32'h0);
      chk("clamped", {pad_out, pad_oe}, 32'h3CFF);
      wait_bit(REG_STATUS, 5, 1'b0);
      #1 chk("rt idle", {31'h0, link.realtime_prog_busy}, 32'h0);
      flop(FL_OP_READ, 4'h5, 16'h0);
      rd(REG_FL_DATA, s);
      chk("erase done", s, 32'hFFFF);
    end
    // Core power lost mid session: flag stays clear, pins and data-out quiet
    wr(REG_CTRL, 32'h1);
    wait_bit(REG_STATUS, 3, 1'b0);
    chk("isp pads", {16'h0, pad_oe, pad_pullup}, 32'h00FF);
    @(posedge core_clk);
    core_power_ok <= 1'b0;
    wait_bit(REG_STATUS, 5, 1'b0);
    repeat (5) @(posedge core_clk);
    rd(REG_STATUS, s);
    chk("flag off", {31'h0, s[3]}, 32'h0);
    chk("pad_oe off", {24'h0, pad_oe}, 32'h0);
    chk("tdo_oe off", {31'h0, link.tdo_oe}, 32'h0);
    test_done();
  end
endmodule : test_isp_flash_interlock
`default_nettype wire

// *** hdl/isp_device_end.sv ***
// Device end: test access controller, user flash block, pin control
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module isp_device_end
  import isp_interlock_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYCLES,
  parameter int WRITE_CYC = WRITE_CYCLES,
  parameter int NPIN = PIN_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link to the programming host
  isp_link_if.dev link,
  // Power and user pin requests
  input wire logic core_power_ok,
  input wire logic [NPIN-1:0] user_out,
  input wire logic [NPIN-1:0] user_oe,
  input wire logic [NPIN-1:0] clamp_val,
  input wire logic [NPIN-1:0] clamp_oe,
  // Pad drive
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe,
  output logic [NPIN-1:0] pad_pullup,
  // Test pin pull resistors
  output logic tdi_pullup,
  output logic tms_pullup,
  output logic tck_pulldown
);
  // Test access controller states
  typedef enum logic [3:0] {
    T_RESET = 4'hF, T_IDLE = 4'hC, T_SEL_DR = 4'h7, T_CAP_DR = 4'h6,
    T_SH_DR = 4'h2, T_EX1_DR = 4'h1, T_PAU_DR = 4'h3, T_EX2_DR = 4'h0,
    T_UPD_DR = 4'h5, T_SEL_IR = 4'h4, T_CAP_IR = 4'hE, T_SH_IR = 4'hA,
    T_EX1_IR = 4'h9, T_PAU_IR = 4'hB, T_EX2_IR = 4'h8, T_UPD_IR = 4'hD
  } tap_t;
  // Flash engine states
  typedef enum logic [1:0] {
    F_IDLE = 2'h0, F_WRITE = 2'h1, F_ERASE = 2'h2
  } fl_state_t;
  // Whole module state
  typedef struct packed {
    logic tck_s1, tck_s2, tck_d;
    logic tms_s1, tms_s2;
    logic tdi_s1, tdi_s2;
    logic pwr_s1, pwr_s2;
    tap_t tap;
    logic [IR_W-1:0] ir_sh, ir;
    logic [DR_W-1:0] dr_sh;
    logic tdo, tdo_oe;
    logic session, rt_lat, clamp_lat;
    logic [7:0] prog_cnt;
    logic flag;
    fl_state_t fst;
    logic [31:0] fcnt;
    logic [FL_AW-1:0] faddr;
    logic [FL_DW-1:0] fdata;
    logic [FL_WORDS-1:0][FL_DW-1:0] mem;
    logic [FL_DW-1:0] rdata;
    logic rvalid;
    logic [NPIN-1:0] p_out, p_oe, p_pu;
  } dev_state_t;

  dev_state_t s_r;  // Registered state
  dev_state_t s_nxt;  // Next state
  logic [NPIN-1:0] pin_out_c;  // Per-pin drive value
  logic [NPIN-1:0] pin_oe_c;  // Per-pin enable
  logic [NPIN-1:0] pin_pu_c;  // Per-pin pull-up

  // Next controller state from mode-select
  function automatic tap_t tap_step(input tap_t st, input logic m);
    case (st)
      T_RESET: tap_step = m ? T_RESET : T_IDLE;  // Stays in reset
      T_IDLE: tap_step = m ? T_SEL_DR : T_IDLE;
      T_SEL_DR: tap_step = m ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: tap_step = m ? T_EX1_DR : T_SH_DR;
      T_SH_DR: tap_step = m ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: tap_step = m ? T_UPD_DR : T_PAU_DR;
      T_PAU_DR: tap_step = m ? T_EX2_DR : T_PAU_DR;
      T_EX2_DR: tap_step = m ? T_UPD_DR : T_SH_DR;
      T_UPD_DR: tap_step = m ? T_SEL_DR : T_IDLE;
      T_SEL_IR: tap_step = m ? T_RESET : T_CAP_IR;
      T_CAP_IR: tap_step = m ? T_EX1_IR : T_SH_IR;
      T_SH_IR: tap_step = m ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: tap_step = m ? T_UPD_IR : T_PAU_IR;
      T_PAU_IR: tap_step = m ? T_EX2_IR : T_PAU_IR;
      T_EX2_IR: tap_step = m ? T_UPD_IR : T_SH_IR;
      T_UPD_IR: tap_step = m ? T_SEL_DR : T_IDLE;
      default: tap_step = T_RESET;
    endcase
  endfunction : tap_step

  // Pin control, one slice per pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_comb begin
        if (s_r.session && (s_r.clamp_lat || s_r.rt_lat)) begin
          pin_out_c[gi] = clamp_val[gi];  // Held at fixed state
          pin_oe_c[gi] = clamp_oe[gi];
          pin_pu_c[gi] = 1'b0;
        end else if (s_r.session) begin
          pin_out_c[gi] = 1'b0;
          pin_oe_c[gi] = 1'b0;  // Tri-stated while programming
          pin_pu_c[gi] = 1'b1;  // Weak pull-up
        end else begin
          pin_out_c[gi] = user_out[gi];
          pin_oe_c[gi] = user_oe[gi] & s_r.flag;  // Drive only when complete
          pin_pu_c[gi] = ~s_r.flag;  // Unprogrammed pins float high
        end
      end
    end
  endgenerate

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    // Pin synchronisers
    s_nxt.tck_s1 = link.tck;
    s_nxt.tck_s2 = s_r.tck_s1;
    s_nxt.tck_d = s_r.tck_s2;
    s_nxt.tms_s1 = link.tms;
    s_nxt.tms_s2 = s_r.tms_s1;
    s_nxt.tdi_s1 = link.tdi;
    s_nxt.tdi_s2 = s_r.tdi_s1;
    s_nxt.pwr_s1 = core_power_ok;
    s_nxt.pwr_s2 = s_r.pwr_s1;
    s_nxt.rvalid = 1'b0;
    // Controller step on each synchronised test clock rise
    if (!s_r.pwr_s2) begin
      s_nxt.tap = T_RESET;  // No core power, test logic inactive
      s_nxt.tdo_oe = 1'b0;  // Data-out left tri-stated
      s_nxt.session = 1'b0;
    end else if (s_r.tck_s2 && !s_r.tck_d) begin
      s_nxt.tap = tap_step(s_r.tap, s_r.tms_s2);
      s_nxt.tdo_oe = 1'b0;
      case (s_r.tap)
        T_RESET: begin
          s_nxt.ir = IR_BYPASS;
        end
        T_CAP_IR: begin
          s_nxt.ir_sh = s_r.ir;
        end
        T_SH_IR: begin
          s_nxt.ir_sh = {s_r.tdi_s2, s_r.ir_sh[IR_W-1:1]};
          s_nxt.tdo = s_r.ir_sh[0];
          s_nxt.tdo_oe = !s_r.tms_s2;
        end
        T_CAP_DR: begin
          s_nxt.dr_sh = s_r.prog_cnt;
        end
        T_SH_DR: begin
          s_nxt.dr_sh = {s_r.tdi_s2, s_r.dr_sh[DR_W-1:1]};
          s_nxt.tdo = s_r.dr_sh[0];
          s_nxt.tdo_oe = !s_r.tms_s2;
        end
        T_UPD_IR: begin
          s_nxt.ir = s_r.ir_sh;
          if (s_r.ir_sh == IR_ENABLE) begin
            s_nxt.session = 1'b1;  // Session opens, flag withdrawn
            s_nxt.flag = 1'b0;
            s_nxt.prog_cnt = '0;
            s_nxt.rt_lat = link.rt_en;
            s_nxt.clamp_lat = link.clamp_en;
          end else if (s_r.ir_sh == IR_DISABLE && s_r.session) begin
            s_nxt.session = 1'b0;
            s_nxt.flag = (s_r.prog_cnt >= 8'(PROG_WORDS));  // Only on success
          end
        end
        T_UPD_DR: begin
          if (s_r.ir == IR_PROGRAM && s_r.session && s_r.prog_cnt != 8'hFF) begin
            s_nxt.prog_cnt = s_r.prog_cnt + 8'h01;
          end
        end
        default: begin
          s_nxt.tdo = s_r.tdo;
        end
      endcase
    end
    // User flash engine
    case (s_r.fst)
      F_IDLE: begin
        // Requests are dropped while a real-time session runs
        if (link.fl_req && !(s_r.session && s_r.rt_lat)) begin
          s_nxt.faddr = link.fl_addr;
          s_nxt.fdata = link.fl_wdata;
          s_nxt.fcnt = '0;
          if (link.fl_op == FL_OP_READ) begin
            s_nxt.rdata = s_r.mem[link.fl_addr];
            s_nxt.rvalid = 1'b1;
          end else if (link.fl_op == FL_OP_WRITE) begin
            s_nxt.fst = F_WRITE;
          end else if (link.fl_op == FL_OP_ERASE) begin
            s_nxt.fst = F_ERASE;
          end
        end
      end
      F_WRITE: begin
        s_nxt.fcnt = s_r.fcnt + 32'd1;
        if (s_r.fcnt == 32'(WRITE_CYC - 1)) begin
          // Programming can only clear bits
          s_nxt.mem[s_r.faddr] = s_r.mem[s_r.faddr] & s_r.fdata;
          s_nxt.fst = F_IDLE;
        end
      end
      F_ERASE: begin
        s_nxt.fcnt = s_r.fcnt + 32'd1;
        // Erase time equals the host's opening wait
        if (s_r.fcnt == 32'(ERASE_CYC - 1)) begin
          for (int k = 0; k < FL_WORDS; k++) begin
            s_nxt.mem[k] = FL_ERASED;
          end
          s_nxt.fst = F_IDLE;
        end
      end
      default: begin
        s_nxt.fst = F_IDLE;
      end
    endcase
    // Registered pad drive
    s_nxt.p_out = pin_out_c;
    s_nxt.p_oe = pin_oe_c;
    s_nxt.p_pu = pin_pu_c;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.tap <= T_RESET;
      s_r.ir <= IR_BYPASS;
      s_r.fst <= F_IDLE;
      s_r.mem <= {FL_WORDS{FL_ERASED}};
      s_r.p_pu <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign link.tdo = s_r.tdo;
  assign link.tdo_oe = s_r.tdo_oe & s_r.pwr_s2;
  assign link.fl_rdata = s_r.rdata;
  assign link.fl_rvalid = s_r.rvalid;
  assign link.fl_busy = (s_r.fst != F_IDLE);
  assign link.realtime_prog_busy = s_r.session & s_r.rt_lat;  // Whole session
  assign link.prog_complete_flag = s_r.flag;
  assign pad_out = s_r.p_out;
  assign pad_oe = s_r.p_oe;
  assign pad_pullup = s_r.p_pu;
  assign tdi_pullup = 1'b1;
  assign tms_pullup = 1'b1;
  assign tck_pulldown = 1'b1;  // Data-out has no pull
endmodule : isp_device_end
`default_nettype wire

// *** hdl/isp_host_end.sv ***
// Host end: flash command gate and programming session sequencer
`timescale 1ns/1ns
`default_nettype none
module isp_host_end
  import isp_interlock_pkg::*;
#(
  parameter int WAIT_CYC = ERASE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Board power
  input wire logic power_good,
  // Link to the device
  isp_link_if.host link
);
  // Session sequencer states
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_FLWAIT = 3'h1, H_POWER = 3'h2, H_ENABLE = 3'h3,
    H_WAIT = 3'h4, H_DATA = 3'h5, H_DISABLE = 3'h6, H_END = 3'h7
  } host_st_t;
  // Whole module state
  typedef struct packed {
    host_st_t hs;
    logic busy_s1, busy_s2, pwr_s1, pwr_s2;
    logic rt_en, clamp_en, session;
    logic [15:0] sq_tms, sq_tdi;
    logic [4:0] sq_left;
    logic [3:0] half;
    logic tck, tms, tdi;
    logic [31:0] wcnt;
    logic fl_req;
    logic [1:0] fl_op;
    logic [FL_AW-1:0] fl_addr;
    logic [FL_DW-1:0] fl_wdata;
    logic fl_busy_d;
    logic [EV_W-1:0] ev_st, ev_mask;
    logic [31:0] rdata;
  } host_state_t;

  host_state_t s_r;  // Registered state
  host_state_t s_nxt;  // Next state
  logic blocked;  // Flash commands withheld
  logic [EV_W-1:0] ev;  // Events this cycle

  // Flash is closed while the sequencer is out of idle, during a session or on synchronised busy
  assign blocked = s_r.busy_s2 || s_r.session || (s_r.hs != H_IDLE);

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    ev = '0;
    s_nxt.busy_s1 = link.realtime_prog_busy;
    s_nxt.busy_s2 = s_r.busy_s1;
    s_nxt.pwr_s1 = power_good;
    s_nxt.pwr_s2 = s_r.pwr_s1;
    s_nxt.fl_req = 1'b0;
    s_nxt.fl_busy_d = link.fl_busy;
    // Scan engine: one test clock period per step
    if (s_r.sq_left != 5'h00) begin
      s_nxt.half = s_r.half + 4'h1;
      if (s_r.half == 4'(TCK_HALF - 1)) begin
        s_nxt.half = '0;
        s_nxt.tck = !s_r.tck;
        if (s_r.tck) begin
          s_nxt.sq_left = s_r.sq_left - 5'h01;
          s_nxt.sq_tms = s_r.sq_tms >> 1;
          s_nxt.sq_tdi = s_r.sq_tdi >> 1;
          s_nxt.tms = s_r.sq_tms[1];
          s_nxt.tdi = s_r.sq_tdi[1];
        end
      end
    end
    // Session sequencer
    case (s_r.hs)
      H_IDLE: begin
        if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START]) begin
          s_nxt.rt_en = reg_wdata[CTRL_RT_EN];
          s_nxt.clamp_en = reg_wdata[CTRL_CLAMP];
          // Real-time sessions rely on the opening wait instead
          s_nxt.hs = reg_wdata[CTRL_RT_EN] ? H_POWER : H_FLWAIT;
        end
      end
      H_FLWAIT: begin
        if (!link.fl_busy && !s_r.fl_req) begin
          s_nxt.hs = H_POWER;  // Erase or write has finished
        end
      end
      H_POWER: begin
        s_nxt.tck = 1'b0;  // Test clock held low, mode-select high until powered
        s_nxt.tms = 1'b1;
        if (s_r.pwr_s2) begin
          s_nxt.sq_tms = SEQ_RESET_TMS;
          s_nxt.sq_tdi = '0;
          s_nxt.sq_left = SEQ_RESET_LEN;
          s_nxt.half = '0;
          s_nxt.hs = H_ENABLE;
        end
      end
      H_ENABLE: begin
        if (s_r.sq_left == 5'h00) begin
          s_nxt.sq_tms = SEQ_IR_TMS;
          s_nxt.sq_tdi = 16'(IR_ENABLE) << SEQ_IR_OFS;
          s_nxt.sq_left = SEQ_IR_LEN;
          s_nxt.tms = SEQ_IR_TMS[0];
          s_nxt.session = 1'b1;
          s_nxt.wcnt = '0;
          s_nxt.hs = s_r.rt_en ? H_WAIT : H_DATA;
        end
      end
      H_WAIT: begin
        if (s_r.sq_left == 5'h00) begin
          s_nxt.wcnt = s_r.wcnt + 32'd1;
          if (s_r.wcnt == 32'(WAIT_CYC - 1)) begin
            s_nxt.wcnt = '0;
            s_nxt.hs = H_DATA;  // First operation after the wait
          end
        end
      end
      H_DATA: begin
        if (s_r.sq_left == 5'h00) begin
          s_nxt.sq_tms = SEQ_DR_TMS;
          s_nxt.sq_tdi = 16'(s_r.wcnt[DR_W-1:0]) << SEQ_DR_OFS;
          s_nxt.sq_left = SEQ_DR_LEN;
          s_nxt.tms = SEQ_DR_TMS[0];
          s_nxt.wcnt = s_r.wcnt + 32'd1;
          if (s_r.wcnt == 32'(PROG_WORDS)) begin
            s_nxt.hs = H_DISABLE;
          end
          if (s_r.wcnt == 32'd0) begin
            // Load the program instruction before the data words
            s_nxt.sq_tms = SEQ_IR_TMS;
            s_nxt.sq_tdi = 16'(IR_PROGRAM) << SEQ_IR_OFS;
            s_nxt.sq_left = SEQ_IR_LEN;
            s_nxt.tms = SEQ_IR_TMS[0];
          end
        end
      end
      H_DISABLE: begin
        if (s_r.sq_left == 5'h00) begin
          s_nxt.sq_tms = SEQ_IR_TMS;
          s_nxt.sq_tdi = 16'(IR_DISABLE) << SEQ_IR_OFS;
          s_nxt.sq_left = SEQ_IR_LEN;
          s_nxt.tms = SEQ_IR_TMS[0];
          s_nxt.hs = H_END;
        end
      end
      H_END: begin
        if (s_r.sq_left == 5'h00) begin
          s_nxt.session = 1'b0;
          s_nxt.hs = H_IDLE;
          ev[EV_DONE] = 1'b1;
        end
      end
      default: begin
        s_nxt.hs = H_IDLE;
      end
    endcase
    // Flash command register
    if (reg_wr && reg_addr == REG_FL_CMD) begin
      if (blocked || link.fl_busy || s_r.fl_req) begin
        ev[EV_REFUSED] = 1'b1;  // Withheld, never reaches flash
      end else begin
        s_nxt.fl_req = 1'b1;
        s_nxt.fl_op = reg_wdata[1:0];
        s_nxt.fl_addr = reg_wdata[CMD_ADDR_LSB +: FL_AW];
        s_nxt.fl_wdata = reg_wdata[CMD_DATA_LSB +: FL_DW];
      end
    end
    if (link.fl_rvalid) begin
      s_nxt.fl_wdata = link.fl_rdata;
    end
    ev[EV_FLASH] = link.fl_rvalid || (s_r.fl_busy_d && !link.fl_busy);
    // Sticky events, set wins over a write-one clear
    if (reg_wr && reg_addr == REG_IRQ_MASK) begin
      s_nxt.ev_mask = reg_wdata[EV_W-1:0];
    end
    s_nxt.ev_st = s_r.ev_st & ~((reg_wr && reg_addr == REG_IRQ_ST) ?
                  reg_wdata[EV_W-1:0] : '0);
    s_nxt.ev_st = s_nxt.ev_st | ev;
    // Read data, valid the cycle after the strobe
    s_nxt.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: s_nxt.rdata = 32'({s_r.clamp_en, s_r.rt_en, 1'b0});
        REG_FL_DATA: s_nxt.rdata = 32'(s_r.fl_wdata);
        REG_STATUS: s_nxt.rdata = 32'({s_r.hs != H_IDLE, link.fl_busy,
                                       link.prog_complete_flag, s_r.busy_s2,
                                       s_r.session, blocked});
        REG_IRQ_ST: s_nxt.rdata = 32'(s_r.ev_st);
        REG_IRQ_MASK: s_nxt.rdata = 32'(s_r.ev_mask);
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.hs <= H_IDLE;
      s_r.tms <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign reg_rdata = s_r.rdata;
  assign irq = |(s_r.ev_st & s_r.ev_mask);
  assign link.tck = s_r.tck;
  assign link.tms = s_r.tms;
  assign link.tdi = s_r.tdi;
  assign link.rt_en = s_r.rt_en;
  assign link.clamp_en = s_r.clamp_en;
  assign link.fl_req = s_r.fl_req;
  assign link.fl_op = s_r.fl_op;
  assign link.fl_addr = s_r.fl_addr;
  assign link.fl_wdata = s_r.fl_wdata;
endmodule : isp_host_end
`default_nettype wire

// *** hdl/isp_interlock_pkg.sv ***
// Shared constants for the flash programming interlock, both ends
// Functional notes
// - Finish flash erase/write before programming session starts
// - Real-time session host waits 500 ms first
// - Sector erase completes within that initial wait
// - Busy output high throughout real-time session
// - No flash activity until real-time session ends
// - User logic itself watches busy, halts flash
// - Complete flag set only after successful sequence
// - Pin drivers off unless complete flag set
// - Default: pins tri-stated, weak pull-up while programming
// - Clamp or real-time: pins held at fixed state
// - Hold test clock low, mode-select high until powered
// - Mode-select high keeps test-logic-reset on clock edges
// - Pull-ups on data-in, mode-select; pull-down clock
// - Without core power test logic idle, data-out tri-stated
package isp_interlock_pkg;
  // Sizes
  localparam int PIN_W = 8;
  localparam int FL_AW = 4;
  localparam int FL_WORDS = 16;
  localparam int FL_DW = 16;
  localparam int IR_W = 4;
  localparam int DR_W = 8;
  localparam int PROG_WORDS = 4;
  localparam int TCK_HALF = 5;
  // Timing, core clock 100 MHz
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int ERASE_TIME_MS = 500;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * CLK_FREQ_KHZ;
  localparam int WRITE_TIME_US = 50;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_KHZ / 1000;
  // Flash operation codes
  localparam logic [1:0] FL_OP_READ = 2'h0;
  localparam logic [1:0] FL_OP_WRITE = 2'h1;
  localparam logic [1:0] FL_OP_ERASE = 2'h2;
  localparam logic [FL_DW-1:0] FL_ERASED = 16'hFFFF;
  // Test instructions
  localparam logic [IR_W-1:0] IR_ENABLE = 4'h1;
  localparam logic [IR_W-1:0] IR_PROGRAM = 4'h2;
  localparam logic [IR_W-1:0] IR_DISABLE = 4'h3;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  // Scan shapes: step masks of mode-select, lengths, data offsets
  localparam logic [15:0] SEQ_RESET_TMS = 16'h001F;
  localparam logic [4:0] SEQ_RESET_LEN = 5'h06;
  localparam logic [15:0] SEQ_IR_TMS = 16'h0183;
  localparam logic [4:0] SEQ_IR_LEN = 5'h0A;
  localparam int SEQ_IR_OFS = 4;
  localparam logic [15:0] SEQ_DR_TMS = 16'h0C01;
  localparam logic [4:0] SEQ_DR_LEN = 5'h0D;
  localparam int SEQ_DR_OFS = 3;
  // Controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FL_CMD = 8'h04;
  localparam logic [7:0] REG_FL_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_ST = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_RT_EN = 1;
  localparam int CTRL_CLAMP = 2;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int EV_DONE = 0;
  localparam int EV_FLASH = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_W = 3;
  localparam int ST_W = 6;
endpackage : isp_interlock_pkg

// *** hdl/isp_link_if.sv ***
// Interface joining the programming host and the device end
`timescale 1ns/1ns
`default_nettype none
interface isp_link_if;
  import isp_interlock_pkg::*;
  // Test access pins
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  // Programming options chosen by the host
  logic rt_en;
  logic clamp_en;
  // User flash access
  logic fl_req;
  logic [1:0] fl_op;
  logic [FL_AW-1:0] fl_addr;
  logic [FL_DW-1:0] fl_wdata;
  logic [FL_DW-1:0] fl_rdata;
  logic fl_rvalid;
  logic fl_busy;
  // Programming state
  logic realtime_prog_busy;
  logic prog_complete_flag;
  modport dev (
    input tck, tms, tdi, rt_en, clamp_en, fl_req, fl_op, fl_addr, fl_wdata,
    output tdo, tdo_oe, fl_rdata, fl_rvalid, fl_busy, realtime_prog_busy,
    output prog_complete_flag
  );
  modport host (
    output tck, tms, tdi, rt_en, clamp_en, fl_req, fl_op, fl_addr, fl_wdata,
    input tdo, tdo_oe, fl_rdata, fl_rvalid, fl_busy, realtime_prog_busy,
    input prog_complete_flag
  );
endinterface : isp_link_if
`default_nettype wire
